// ===== rtl/mcor_group.sv
// one logic block group: cells, clocks, init, output routing, input gating
// What this block does
// - cluster n may feed cluster n+4
// - clock enable picks term, inverted, shared, high
// - block init term reaches every cell
// - two stolen terms give individual set, reset
// - per-cell swap exchanges reset and preset
// - swap setting also fixes power-up state
// - set-on-block-init cells power up set
// - other cells power up reset
// - global clock pins reach generator and routing
// - four group clocks from true/complement globals
// - output enable follows output to chosen pin
// - one routing slice per I/O cell
// - sixteen I/O: window starts at cell k
// - eight I/O: window starts at cell 2k
// - twelve I/O: windows start 0,1,2,4,5,6...
// - pin gets enable term of routed cell
// - one input gate enable per block
// - gate enable from cell logic or pin
// - each pin may ignore the gate enable
// - two feedbacks may carry oscillator, divider
// - cells drive divider clear and clock gate
// - divider output is oscillator over ratio
module mcor_group (
    input  wire logic                    sys_clk,
    input  wire logic                    arst_n,
    input  wire logic [3:0]              global_clk_pin,
    input  wire logic [15:0]             cluster_sum,
    input  wire logic [15:0]             term_clock,
    input  wire logic [15:0]             term_init_or_enable,
    input  wire logic [15:0]             term_set,
    input  wire logic [15:0]             term_reset,
    input  wire logic [15:0]             term_oe,
    input  wire logic                    shared_term_clock,
    input  wire logic                    block_init,
    input  mcor_pkg::mcor_cell_cfg_t [15:0] cell_cfg,
    input  mcor_pkg::mcor_gclk_cfg_t [3:0]  gclk_cfg,
    input  wire logic [15:0][2:0]        slice_sel,
    input  mcor_pkg::mcor_blk_cfg_t      blk_cfg,
    input  wire logic [15:0]             io_in_pin,
    input  wire logic                    bie_pin,
    input  wire logic [15:0]             pin_ignore_bie,
    input  wire logic                    ring_clock_out,
    output logic [15:0]                  cell_q,
    output logic [15:0]                  cell_feedback,
    output logic [3:0]                   group_clock,
    output logic [3:0]                   grp_clock_pins,
    output logic [15:0]                  io_out,
    output logic [15:0]                  io_oe_n,
    output logic [15:0]                  io_in_gated,
    output logic                         divider_clear,
    output logic                         runtime_clock_gate,
    output logic                         divided_clock_out
);
    logic [3:0]  gclk_m;
    logic [3:0]  gclk_s;
    logic [15:0] pin_m;
    logic [15:0] pin_s;
    logic        bie_m;
    logic        bie_s;
    logic        osc_m;
    logic        osc_s;
    logic        pending;
    logic [3:0]  next_group_clock;
    logic [15:0] wide_sum;
    logic [15:0] sel_lvl;
    logic [15:0] sel_prev;
    logic [15:0] clk_evt;
    logic [15:0] ce_lvl;
    logic [15:0] rst_eff;
    logic [15:0] set_eff;
    logic [15:0] pup;
    logic [15:0] next_io_out;
    logic [15:0] next_io_oe_n;
    logic        bie_lvl;
    logic        ring_gated;

    // every pin-side input passes two flops before any use
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            gclk_m <= mcor_pkg::MCOR_GCLK_RST;
            gclk_s <= mcor_pkg::MCOR_GCLK_RST;
            pin_m  <= mcor_pkg::MCOR_Q_RST;
            pin_s  <= mcor_pkg::MCOR_Q_RST;
            bie_m  <= 1'h0;
            bie_s  <= 1'h0;
            osc_m  <= 1'h0;
            osc_s  <= 1'h0;
        end else begin
            gclk_m <= global_clk_pin;
            gclk_s <= gclk_m;
            pin_m  <= io_in_pin;
            pin_s  <= pin_m;
            bie_m  <= bie_pin;
            bie_s  <= bie_m;
            osc_m  <= ring_clock_out;
            osc_s  <= osc_m;
        end
    end

    always_comb begin
        for (int g = 0; g < mcor_pkg::MCOR_GCLKS; g++) begin
            next_group_clock[g] = gclk_s[gclk_cfg[g].src]
                                ^ gclk_cfg[g].invert;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            group_clock    <= mcor_pkg::MCOR_GCLK_RST;
            grp_clock_pins <= mcor_pkg::MCOR_GCLK_RST;
        end else begin
            group_clock    <= next_group_clock;
            grp_clock_pins <= gclk_s;
        end
    end

    always_comb begin
        for (int n = 0; n < mcor_pkg::MCOR_CELLS; n++) begin
            if (n >= mcor_pkg::MCOR_CHAIN_STEP && cell_cfg[n].chain_en) begin
                wide_sum[n] = cluster_sum[n]
                            | wide_sum[n - mcor_pkg::MCOR_CHAIN_STEP];
            end else begin
                wide_sum[n] = cluster_sum[n];
            end
        end
    end

    always_comb begin
        for (int i = 0; i < mcor_pkg::MCOR_CELLS; i++) begin
            case (cell_cfg[i].clk_sel)
                mcor_pkg::MCOR_CK_G0:     sel_lvl[i] = group_clock[0];
                mcor_pkg::MCOR_CK_G1:     sel_lvl[i] = group_clock[1];
                mcor_pkg::MCOR_CK_G2:     sel_lvl[i] = group_clock[2];
                mcor_pkg::MCOR_CK_G3:     sel_lvl[i] = group_clock[3];
                mcor_pkg::MCOR_CK_TERM:   sel_lvl[i] = term_clock[i];
                mcor_pkg::MCOR_CK_TERM_N: sel_lvl[i] = ~term_clock[i];
                mcor_pkg::MCOR_CK_SHARED: sel_lvl[i] = shared_term_clock;
                default:                  sel_lvl[i] = 1'h0;
            endcase
            case (cell_cfg[i].ce_sel)
                mcor_pkg::MCOR_CE_TERM:   ce_lvl[i] = term_init_or_enable[i];
                mcor_pkg::MCOR_CE_TERM_N: ce_lvl[i] = ~term_init_or_enable[i];
                mcor_pkg::MCOR_CE_SHARED: ce_lvl[i] = shared_term_clock;
                default:                  ce_lvl[i] = 1'h1;
            endcase
            // swap turns block and individual resets into presets
            rst_eff[i] = (cell_cfg[i].block_init_used & block_init
                          & ~cell_cfg[i].swap)
                       | (cell_cfg[i].indiv_sr_en
                          & (cell_cfg[i].swap ? term_set[i]
                                              : term_reset[i]));
            set_eff[i] = (cell_cfg[i].block_init_used & block_init
                          & cell_cfg[i].swap)
                       | (cell_cfg[i].indiv_sr_en
                          & (cell_cfg[i].swap ? term_reset[i]
                                              : term_set[i]));
            pup[i] = cell_cfg[i].block_init_used & cell_cfg[i].swap;
        end
    end

    assign clk_evt = sel_lvl & ~sel_prev;

    // power-up state is loaded one edge after release, since the
    // async reset may only load constants; no clock event is taken
    // before that edge
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pending  <= mcor_pkg::MCOR_PENDING_RST;
            sel_prev <= mcor_pkg::MCOR_Q_RST;
            cell_q   <= mcor_pkg::MCOR_Q_RST;
        end else if (pending) begin
            pending  <= 1'h0;
            sel_prev <= sel_lvl;
            cell_q   <= pup;
        end else begin
            sel_prev <= sel_lvl;
            for (int i = 0; i < mcor_pkg::MCOR_CELLS; i++) begin
                // reset wins over set, as in the register cell
                if (rst_eff[i]) begin
                    cell_q[i] <= 1'h0;
                end else if (set_eff[i]) begin
                    cell_q[i] <= 1'h1;
                end else if (clk_evt[i] && ce_lvl[i]) begin
                    cell_q[i] <= wide_sum[i];
                end
            end
        end
    end

    assign ring_gated = osc_s & ~runtime_clock_gate;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cell_feedback      <= mcor_pkg::MCOR_Q_RST;
            divider_clear      <= 1'h0;
            runtime_clock_gate <= 1'h0;
        end else begin
            cell_feedback <= cell_q;
            if (blk_cfg.osc_fb_en) begin
                cell_feedback[mcor_pkg::MCOR_OSC_CELL] <= ring_gated;
            end
            if (blk_cfg.timer_fb_en) begin
                cell_feedback[mcor_pkg::MCOR_TIMER_CELL] <=
                    divided_clock_out;
            end
            divider_clear      <= cell_q[mcor_pkg::MCOR_CLEAR_CELL];
            runtime_clock_gate <= cell_q[mcor_pkg::MCOR_GATE_CELL];
        end
    end

    mcor_divider mcor_divider_inst (
        .sys_clk   (sys_clk),
        .arst_n    (arst_n),
        .osc_level (ring_gated),
        .clear     (divider_clear),
        .div_exp   (blk_cfg.div_exp),
        .divided   (divided_clock_out)
    );

    function automatic logic slice_active(mcor_pkg::mcor_io_mode_t m,
                                          logic [3:0]              k);
        case (m)
            mcor_pkg::MCOR_IO12: slice_active = k < mcor_pkg::MCOR_IO12_LIMIT;
            mcor_pkg::MCOR_IO8:  slice_active = k < mcor_pkg::MCOR_IO8_LIMIT;
            default:             slice_active = 1'h1;
        endcase
    endfunction

    always_comb begin
        logic [3:0] src;
        src = 4'h0;
        for (int k = 0; k < mcor_pkg::MCOR_CELLS; k++) begin
            // 4-bit sum wraps the window modulo sixteen
            src = mcor_pkg::mcor_win_start(blk_cfg.io_mode, 4'(k))
                + {1'b0, slice_sel[k]};
            if (slice_active(blk_cfg.io_mode, 4'(k))) begin
                next_io_out[k]  = cell_q[src];
                next_io_oe_n[k] = ~term_oe[src];
            end else begin
                next_io_out[k]  = 1'h0;
                next_io_oe_n[k] = 1'h1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            io_out  <= mcor_pkg::MCOR_Q_RST;
            io_oe_n <= mcor_pkg::MCOR_OE_N_RST;
        end else begin
            io_out  <= next_io_out;
            io_oe_n <= next_io_oe_n;
        end
    end

    assign bie_lvl = blk_cfg.bie_from_pin ? bie_s
                                          : cell_q[blk_cfg.bie_cell];

    // a blocked pin holds its last value so nothing inside toggles
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            io_in_gated <= mcor_pkg::MCOR_Q_RST;
        end else begin
            for (int j = 0; j < mcor_pkg::MCOR_CELLS; j++) begin
                if (bie_lvl || pin_ignore_bie[j]) begin
                    io_in_gated[j] <= pin_s[j];
                end
            end
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    power_up_a: assert property (pending |=> cell_q == $past(pup))
        else $error("cells left power-up in the wrong state");
    block_init_a: assert property (!pending && block_init
        |=> (~cell_q
             & $past(pup)
             & $past(~rst_eff)) == 16'h0000)
        else $error("block init did not set a swapped cell");
    blk_reset_a: assert property (!pending && block_init
        |=> (cell_q & $past(rst_eff)) == 16'h0000)
        else $error("block init reset did not clear the cell");
    indiv_set_a: assert property (!pending
        |=> (~cell_q & $past(set_eff & ~rst_eff)) == 16'h0000)
        else $error("individual set did not set the cell");
    ground_hold_a: assert property (!pending
        && cell_cfg[0].clk_sel == mcor_pkg::MCOR_CK_GND
        && !rst_eff[0] && !set_eff[0] |=> $stable(cell_q[0]))
        else $error("grounded clock still loaded a cell");
    chain_load_a: assert property (!pending && cell_cfg[6].chain_en
        && cluster_sum[2] && clk_evt[6]
        && ce_lvl[6] && !rst_eff[6] && !set_eff[6] |=> cell_q[6])
        else $error("chained cluster did not reach cell six");
    gclk_gen_a: assert property (1'b1
        |=> group_clock[1] == $past(gclk_s[gclk_cfg[1].src]
                                    ^ gclk_cfg[1].invert))
        else $error("group clock built from the wrong global clock");
    wrap16_a: assert property (blk_cfg.io_mode == mcor_pkg::MCOR_IO16
        && slice_sel[15] == 3'h3 |=> io_out[15] == $past(cell_q[2]))
        else $error("slice fifteen did not wrap to cell two");
    win8_a: assert property (blk_cfg.io_mode == mcor_pkg::MCOR_IO8
        && slice_sel[3] == 3'h7 |=> io_out[3] == $past(cell_q[13]))
        else $error("eight pin window misplaced");
    win12_a: assert property (blk_cfg.io_mode == mcor_pkg::MCOR_IO12
        && slice_sel[11] == 3'h7 |=> io_out[11] == $past(cell_q[5]))
        else $error("twelve pin window misplaced");
    oe_follow_a: assert property (blk_cfg.io_mode == mcor_pkg::MCOR_IO16
        |=> io_oe_n[0] == !$past(term_oe[slice_sel[0]]))
        else $error("enable term did not follow the output");
    bie_block_a: assert property (!bie_lvl && !pin_ignore_bie[1]
        |=> $stable(io_in_gated[1]))
        else $error("gated pin input changed");
    bie_ignore_a: assert property (pin_ignore_bie[0]
        |=> io_in_gated[0] == $past(pin_s[0]))
        else $error("ignoring pin was still gated");
    osc_fb_a: assert property (blk_cfg.osc_fb_en
        |=> cell_feedback[15] == $past(ring_gated))
        else $error("oscillator not on the feedback line");

    pup_set_c: cover property (pending && pup[0]);
    chain_c: cover property (!pending && cell_cfg[8].chain_en
        && cell_cfg[4].chain_en && clk_evt[8]);
    gate_c: cover property (!bie_lvl ##1 bie_lvl);
endmodule

// ===== rtl/mcor_pkg.sv
// shared constants, types and the output window function for the block
package mcor_pkg;
    localparam int         MCOR_CELLS       = 16;
    localparam int         MCOR_GCLKS       = 4;
    localparam int         MCOR_CHAIN_STEP  = 4;
    localparam int         MCOR_DIV_W       = 20;
    localparam logic [4:0] MCOR_DIV_EXP_MAX = 5'h14;
    localparam logic [4:0] MCOR_DIV_EXP_KHZ = 5'h0A;
    localparam logic [3:0] MCOR_OSC_CELL    = 4'hF;
    localparam logic [3:0] MCOR_TIMER_CELL  = 4'hE;
    localparam logic [3:0] MCOR_CLEAR_CELL  = 4'hD;
    localparam logic [3:0] MCOR_GATE_CELL   = 4'hC;
    localparam logic [3:0] MCOR_IO12_LIMIT  = 4'hC;
    localparam logic [3:0] MCOR_IO8_LIMIT   = 4'h8;
    localparam logic       MCOR_PENDING_RST = 1'h1;
    localparam logic [15:0] MCOR_Q_RST      = 16'h0000;
    localparam logic [15:0] MCOR_OE_N_RST   = 16'hFFFF;
    localparam logic [3:0] MCOR_GCLK_RST    = 4'h0;
    localparam logic [19:0] MCOR_CNT_RST    = 20'h00000;

    typedef enum logic [2:0] {
        MCOR_CK_G0,
        MCOR_CK_G1,
        MCOR_CK_G2,
        MCOR_CK_G3,
        MCOR_CK_TERM,
        MCOR_CK_TERM_N,
        MCOR_CK_SHARED,
        MCOR_CK_GND
    } mcor_clk_sel_t;

    typedef enum logic [1:0] {
        MCOR_CE_TERM,
        MCOR_CE_TERM_N,
        MCOR_CE_SHARED,
        MCOR_CE_HIGH
    } mcor_ce_sel_t;

    typedef enum logic [1:0] {
        MCOR_IO16,
        MCOR_IO12,
        MCOR_IO8,
        MCOR_IO_RSVD
    } mcor_io_mode_t;

    typedef struct packed {
        mcor_clk_sel_t clk_sel;
        mcor_ce_sel_t  ce_sel;
        logic          block_init_used;
        logic          swap;
        logic          indiv_sr_en;
        logic          chain_en;
    } mcor_cell_cfg_t;

    typedef struct packed {
        logic [1:0] src;
        logic       invert;
    } mcor_gclk_cfg_t;

    typedef struct packed {
        mcor_io_mode_t io_mode;
        logic          bie_from_pin;
        logic [3:0]    bie_cell;
        logic          osc_fb_en;
        logic          timer_fb_en;
        logic [4:0]    div_exp;
    } mcor_blk_cfg_t;

    // first cell of the eight-cell window feeding I/O slice k
    function automatic logic [3:0] mcor_win_start(mcor_io_mode_t m,
                                                  logic [3:0]    k);
        logic [3:0] third;
        third = k / 4'h3;
        case (m)
            MCOR_IO8:  mcor_win_start = {k[2:0], 1'b0};
            MCOR_IO12: mcor_win_start = k + third;
            default:   mcor_win_start = k;
        endcase
    endfunction
endpackage

// ===== rtl/mcor_divider.sv
// oscillator divider: counts oscillator edges, divides by 2^div_exp
module mcor_divider (
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic       osc_level,
    input  wire logic       clear,
    input  wire logic [4:0] div_exp,
    output logic            divided
);
    logic                          osc_prev;
    logic                          osc_rise;
    logic [mcor_pkg::MCOR_DIV_W-1:0] cnt;
    logic [mcor_pkg::MCOR_DIV_W-1:0] next_cnt;
    logic [4:0]                    exp_eff;

    assign osc_rise = osc_level & ~osc_prev;

    always_comb begin
        // ratios beyond the counter width clamp to the slowest one
        if (div_exp > mcor_pkg::MCOR_DIV_EXP_MAX) begin
            exp_eff = mcor_pkg::MCOR_DIV_EXP_MAX;
        end else begin
            exp_eff = div_exp;
        end
        if (clear) begin
            next_cnt = mcor_pkg::MCOR_CNT_RST;
        end else if (osc_rise) begin
            next_cnt = cnt + 20'h00001;
        end else begin
            next_cnt = cnt;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            osc_prev <= 1'h0;
            cnt      <= mcor_pkg::MCOR_CNT_RST;
            divided  <= 1'h0;
        end else begin
            osc_prev <= osc_level;
            cnt      <= next_cnt;
            if (exp_eff == 5'h00) begin
                divided <= osc_level;
            end else begin
                divided <= next_cnt[exp_eff - 5'h01];
            end
        end
    end

    div_toggle_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        osc_rise && !clear && exp_eff == 5'h01 && $stable(div_exp)
        |=> divided != $past(divided))
        else $error("divide by two output did not toggle");
    div_clear_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        clear && exp_eff != 5'h00 |=> !divided && cnt == 20'h00000)
        else $error("divider clear did not zero the output");
    div_slow_c: cover property (@(posedge sys_clk) disable iff (!arst_n)
        exp_eff == mcor_pkg::MCOR_DIV_EXP_KHZ && $rose(divided));
endmodule

// ===== test/mcor_group_test.sv
// self-checking bench for the logic block group
module mcor_group_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] PAT = 16'hA5C3;
    logic sys_clk, arst_n, shared_term_clock, block_init, bie_pin;
    logic ring_clock_out;
    logic [3:0]  global_clk_pin;
    logic [15:0] cluster_sum, term_clock, term_init_or_enable;
    logic [15:0] term_set, term_reset, term_oe, io_in_pin, pin_ignore_bie;
    mcor_pkg::mcor_cell_cfg_t [15:0] cell_cfg;
    mcor_pkg::mcor_gclk_cfg_t [3:0]  gclk_cfg;
    logic [15:0][2:0]                slice_sel;
    mcor_pkg::mcor_blk_cfg_t         blk_cfg;
    logic [15:0] cell_q, cell_feedback, io_out, io_oe_n, io_in_gated, q_exp;
    logic [3:0]  group_clock, grp_clock_pins;
    logic        divider_clear, runtime_clock_gate, divided_clock_out;
    int          bad_count, checks_done;

    mcor_group mcor_group_inst (
        .sys_clk(sys_clk), .arst_n(arst_n), .global_clk_pin(global_clk_pin),
        .cluster_sum(cluster_sum), .term_clock(term_clock),
        .term_init_or_enable(term_init_or_enable), .term_set(term_set),
        .term_reset(term_reset), .term_oe(term_oe),
        .shared_term_clock(shared_term_clock), .block_init(block_init),
        .cell_cfg(cell_cfg), .gclk_cfg(gclk_cfg), .slice_sel(slice_sel),
        .blk_cfg(blk_cfg), .io_in_pin(io_in_pin), .bie_pin(bie_pin),
        .pin_ignore_bie(pin_ignore_bie), .ring_clock_out(ring_clock_out),
        .cell_q(cell_q), .cell_feedback(cell_feedback),
        .group_clock(group_clock), .grp_clock_pins(grp_clock_pins),
        .io_out(io_out), .io_oe_n(io_oe_n), .io_in_gated(io_in_gated),
        .divider_clear(divider_clear),
        .runtime_clock_gate(runtime_clock_gate),
        .divided_clock_out(divided_clock_out)
    );

    initial sys_clk = 1'b0;
    always #20 sys_clk = ~sys_clk;

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask

    task automatic stop_test;
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // one rising edge on the masked term clocks, low for one edge first
    task automatic pulse_clk(input logic [15:0] m);
        term_clock = 16'h0000;
        tick(1);
        term_clock = m;
        tick(1);
    endtask

    // divider latency is not fixed, so poll under a bound
    task automatic wait_div(input logic v);
        int n;
        n = 0;
        while (divided_clock_out !== v && n < 20) begin
            tick(1);
            n++;
        end
        if (divided_clock_out !== v) begin
            bad_count++;
            $display("CHECK FAILED at %0t: divider output stuck", $time);
            stop_test();
        end else begin
            check({15'h0000, divided_clock_out}, {15'h0000, v}, "div");
        end
    endtask

    task automatic test_power_up;
        check(io_oe_n, 16'hFFFF, "oe during reset");
        check(cell_q, 16'h0000, "q during reset");
        arst_n = 1'b1;
        tick(1);
        check(cell_q, 16'h0033, "power-up state");
    endtask

    task automatic test_block_init;
        for (int i = 0; i < 16; i++) cell_cfg[i].block_init_used = 1'b1;
        for (int i = 0; i < 16; i++) cell_cfg[i].swap = PAT[i];
        block_init = 1'b1;
        tick(1);
        check(cell_q, PAT, "block init");
        for (int i = 0; i < 16; i++) cell_cfg[i].swap = ~PAT[i];
        tick(1);
        check(cell_q, ~PAT, "block init swapped");
        block_init = 1'b0;
        for (int i = 0; i < 16; i++) cell_cfg[i].block_init_used = 1'b0;
        q_exp = ~PAT;
    endtask

    task automatic test_routing;
        logic [3:0]  src;
        logic [15:0] eo, en;
        int          st;
        for (int m = 0; m < 3; m++) begin
            blk_cfg.io_mode = mcor_pkg::mcor_io_mode_t'(m);
            tick(2);
            eo = 16'h0000;
            en = 16'hFFFF;
            for (int k = 0; k < 16 - 4 * m; k++) begin
                st = (m == 0) ? k : (m == 1) ? k + k / 3 : 2 * k;
                src = 4'(st + int'(slice_sel[k]));
                eo[k] = q_exp[src];
                en[k] = ~term_oe[src];
            end
            check(io_out, eo, "routed output");
            check(io_oe_n, en, "routed enable");
        end
        blk_cfg.io_mode = mcor_pkg::MCOR_IO16;
    endtask

    task automatic test_set_reset;
        cell_cfg[1].indiv_sr_en = 1'b1;
        cell_cfg[1].swap = 1'b0;
        term_set = 16'h0002;
        tick(1);
        q_exp[1] = 1'b1;
        check(cell_q, q_exp, "own set");
        term_set = 16'h0000;
        term_reset = 16'h0002;
        tick(1);
        q_exp[1] = 1'b0;
        check(cell_q, q_exp, "own reset");
        cell_cfg[1].swap = 1'b1;
        tick(1);
        q_exp[1] = 1'b1;
        check(cell_q, q_exp, "swapped reset sets");
        term_set = 16'h0002;
        tick(1);
        q_exp[1] = 1'b0;
        check(cell_q, q_exp, "reset wins");
        term_set = 16'h0000;
        term_reset = 16'h0000;
        cell_cfg[1].indiv_sr_en = 1'b0;
    endtask

    task automatic test_clocking;
        // all term clocks toggle: cells left on ground must not load
        cell_cfg[0].clk_sel = mcor_pkg::MCOR_CK_TERM;
        cluster_sum = 16'hFFFF;
        pulse_clk(16'hFFFF);
        q_exp[0] = 1'b1;
        check(cell_q, q_exp, "term clock load");
        cluster_sum = 16'h0000;
        term_clock = 16'h0000;
        tick(1);
        check(cell_q, q_exp, "falling edge ignored");
        pulse_clk(16'hFFFF);
        q_exp[0] = 1'b0;
        check(cell_q, q_exp, "term clock load zero");
        cell_cfg[0].ce_sel = mcor_pkg::MCOR_CE_TERM_N;
        term_init_or_enable = 16'h0001;
        cluster_sum = 16'hFFFF;
        pulse_clk(16'hFFFF);
        check(cell_q, q_exp, "inverted enable blocks");
        cell_cfg[0].ce_sel = mcor_pkg::MCOR_CE_TERM;
        pulse_clk(16'hFFFF);
        q_exp[0] = 1'b1;
        check(cell_q, q_exp, "term enable passes");
        cell_cfg[0].clk_sel = mcor_pkg::MCOR_CK_GND;
        cell_cfg[0].ce_sel = mcor_pkg::MCOR_CE_HIGH;
        term_init_or_enable = 16'h0000;
    endtask

    task automatic test_chain;
        cell_cfg[6].clk_sel = mcor_pkg::MCOR_CK_TERM;
        cell_cfg[6].chain_en = 1'b1;
        cluster_sum = 16'h0004;
        pulse_clk(16'h0040);
        q_exp[6] = 1'b1;
        check(cell_q, q_exp, "chained sum");
        cell_cfg[6].chain_en = 1'b0;
        pulse_clk(16'h0040);
        q_exp[6] = 1'b0;
        check(cell_q, q_exp, "chain off");
        cell_cfg[6].clk_sel = mcor_pkg::MCOR_CK_GND;
        term_clock = 16'h0000;
    endtask

    task automatic test_gate;
        io_in_pin = 16'h0003;
        tick(3);
        check(io_in_gated, 16'h0001, "gated pin frozen");
        bie_pin = 1'b1;
        tick(3);
        check(io_in_gated, 16'h0003, "gate open");
        blk_cfg.bie_from_pin = 1'b0;
        blk_cfg.bie_cell = 4'h7;
        io_in_pin = 16'hFFFF;
        tick(3);
        check(io_in_gated, 16'h0003, "cell gate closed");
        blk_cfg.bie_cell = 4'h4;
        tick(3);
        check(io_in_gated, 16'hFFFF, "cell gate open");
    endtask

    task automatic test_gclk;
        gclk_cfg[0] = {2'h1, 1'b0};
        gclk_cfg[1] = {2'h1, 1'b1};
        global_clk_pin = 4'h2;
        tick(3);
        check({12'h000, group_clock}, 16'h0001, "group clocks");
        check({12'h000, grp_clock_pins}, 16'h0002, "pins to pool");
        global_clk_pin = 4'h0;
        tick(3);
        check({12'h000, group_clock}, 16'h0002, "group clocks low");
    endtask

    task automatic test_divider;
        check({15'h0000, runtime_clock_gate}, 16'h0001, "gate");
        cell_cfg[12].block_init_used = 1'b1;
        cell_cfg[13].block_init_used = 1'b1;
        cell_cfg[12].swap = 1'b0;
        cell_cfg[13].swap = 1'b0;
        block_init = 1'b1;
        tick(1);
        block_init = 1'b0;
        tick(2);
        ring_clock_out = 1'b1;
        wait_div(1'b1);
        tick(2);
        check({14'h0000, cell_feedback[15:14]}, 16'h0003, "feeds");
        ring_clock_out = 1'b0;
        cell_cfg[13].swap = 1'b1;
        block_init = 1'b1;
        tick(1);
        block_init = 1'b0;
        tick(1);
        check({15'h0000, divider_clear}, 16'h0001, "clear from cell");
        wait_div(1'b0);
    endtask

    initial begin
        bad_count = 0;
        checks_done = 0;
        arst_n = 1'b0;
        global_clk_pin = 4'h0;
        cluster_sum = 16'h0000;
        term_clock = 16'h0000;
        term_init_or_enable = 16'h0000;
        term_set = 16'h0000;
        term_reset = 16'h0000;
        term_oe = 16'h3C96;
        shared_term_clock = 1'b0;
        block_init = 1'b0;
        io_in_pin = 16'h0000;
        bie_pin = 1'b0;
        pin_ignore_bie = 16'h0001;
        ring_clock_out = 1'b0;
        gclk_cfg = '0;
        blk_cfg = {mcor_pkg::MCOR_IO16, 1'b1, 4'h0, 1'b1, 1'b1, 5'h01};
        for (int k = 0; k < 16; k++) slice_sel[k] = 3'(k * 5);
        // power-up mix: set-on-init, reset-on-init, and unconfigured
        for (int i = 0; i < 16; i++) begin
            cell_cfg[i] = {mcor_pkg::MCOR_CK_GND, mcor_pkg::MCOR_CE_HIGH,
                           i < 8, (16'h0F33 >> i) & 16'h0001 ? 1'b1 : 1'b0,
                           1'b0, 1'b0};
        end
        tick(5);
        test_power_up();
        test_block_init();
        test_routing();
        test_set_reset();
        test_clocking();
        test_chain();
        test_gate();
        test_gclk();
        test_divider();
        stop_test();
    end
endmodule
